/* File: rtl/carrier_config_trigger_regs.sv */
// Behaviour
// - Carrier registers reached only with module zero
// - Error flag sticky, cleared by writing one
// - Logic version read-only, major high, minor low
// - Firmware version read-only, major high, minor low
// - Eight read/write slot reset bits drive resets
// - Slot reset bits never self-clear
// - Fan select bit 15: 0 variable, 1 full
// - Fan select non-volatile, factory default full
// - Temperatures are read-only 10-bit fields
// - Logic and slot area temperature registers
// - Trigger A 0x10-0x1F, trigger B 0x20-0x2F
// - Trigger entries hold enable, polarity, edge bits
// - Trigger entries hold direction and edge/level bits
// - Source type codes select TTL, LVDS, A, B
// - Source index gives source or edge clock
// - LVDS trigger registers at 0x30-0x3F
// - TTL input control 0x50, output select 0x52
// - Edge clock sources at 0x58 and 0x5A
`timescale 1ns/1ps
`include "carrier_regs_defines.svh"

module carrier_config_trigger_regs
    import carrier_regs_pkg::*;
#(
    // Arbitrary neutral identification values
    parameter logic [11:0] MAKER_CODE = 12'h0a5,
    parameter logic [11:0] PART_CODE = 12'h05a,
    parameter logic [7:0] LOGIC_VER_MAJOR = 8'h01,
    parameter logic [7:0] LOGIC_VER_MINOR = 8'h00,
    parameter logic [7:0] FW_VER_MAJOR = 8'h01,
    parameter logic [7:0] FW_VER_MINOR = 8'h00,
    parameter int SLOTS = 8,
    parameter int TRIG_ENTRIES = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register access from the command decoder
    input wire logic [7:0] module_sel,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // Events and sensor inputs
    input wire logic command_error,
    input wire logic [9:0] fan_area_temp,
    input wire logic [9:0] logic_area_temp,
    input wire logic [9:0] slot_area_temp,
    // Non-volatile fan setting
    input wire logic nv_valid,
    input wire logic nv_fan_speed_select,
    output logic nv_store,
    output logic nv_store_value,
    // Control outputs
    output logic [7:0] slot_reset_bit,
    output logic fan_speed_select,
    output logic [15:0] trig_a_cfg [TRIG_ENTRIES],
    output logic [15:0] trig_b_cfg [TRIG_ENTRIES],
    output logic [15:0] lvds_cfg [TRIG_ENTRIES],
    output logic [15:0] ttl_in_cfg,
    output logic [15:0] ttl_out_cfg,
    output logic [15:0] eclk_01_cfg,
    output logic [15:0] eclk_23_cfg
);

    ////////////////////////////////////////////////////////////////////////
    logic rst_sync1_r;
    logic rst_sync2_r;
    logic sel_carrier;
    logic wr_en;
    logic rd_en;
    logic cmd_err_r;
    logic fan_sel_r;
    logic nv_loaded_r;
    logic [7:0] slot_rst_r;
    word_t rdata_nxt;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_sync1_r <= 1'b0;
            rst_sync2_r <= 1'b0;
        end
        else
        begin
            rst_sync1_r <= 1'b1;
            rst_sync2_r <= rst_sync1_r;
        end
    end

    // Word index of a byte address; even addresses only
    function automatic logic [2:0] entry_idx(input logic [7:0] a);
        entry_idx = a[3:1];
    endfunction : entry_idx

    function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                      input logic [7:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    assign sel_carrier = (module_sel == 8'h00);
    assign wr_en = reg_wr && sel_carrier && !reg_addr[0];
    assign rd_en = reg_rd && sel_carrier;

    ////////////////////////////////////////////////////////////////////////
    // Sticky error: a new error in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
            cmd_err_r <= 1'b0;
        else if (command_error)
            cmd_err_r <= 1'b1;
        else if (wr_en && reg_addr == `OFS_ERR_MAKER && reg_wdata[`BIT_CMD_ERR])
            cmd_err_r <= 1'b0;
    end

    // Slot resets change only on software writes
    always_ff @(posedge clk or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
            slot_rst_r <= `SLOT_RST_INIT;
        else if (wr_en && reg_addr == `OFS_SLOT_RST)
            slot_rst_r <= reg_wdata[7:0];
    end

    // Fan select starts at factory default, then takes the stored copy unless software writes it first
    always_ff @(posedge clk or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
        begin
            fan_sel_r <= `FAN_SEL_FACTORY;
            nv_loaded_r <= 1'b0;
        end
        else if (wr_en && reg_addr == `OFS_FAN)
        begin
            fan_sel_r <= reg_wdata[`BIT_FAN_SEL];
            nv_loaded_r <= 1'b1;
        end
        else if (!nv_loaded_r && nv_valid)
        begin
            fan_sel_r <= nv_fan_speed_select;
            nv_loaded_r <= 1'b1;
        end
    end

    // Every fan write is pushed to non-volatile storage
    always_ff @(posedge clk or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
        begin
            nv_store <= 1'b0;
            nv_store_value <= `FAN_SEL_FACTORY;
        end
        else
        begin
            nv_store <= wr_en && reg_addr == `OFS_FAN;
            if (wr_en && reg_addr == `OFS_FAN)
                nv_store_value <= reg_wdata[`BIT_FAN_SEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Routing registers; the fields are consumed by the trigger matrix
    always_ff @(posedge clk or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
        begin
            for (int i = 0; i < TRIG_ENTRIES; i++)
            begin
                trig_a_cfg[i] <= 16'h0000;
                trig_b_cfg[i] <= 16'h0000;
                lvds_cfg[i] <= 16'h0000;
            end
            ttl_in_cfg <= 16'h0000;
            ttl_out_cfg <= 16'h0000;
            eclk_01_cfg <= 16'h0000;
            eclk_23_cfg <= 16'h0000;
        end
        else if (wr_en)
        begin
            if (in_range(reg_addr, `OFS_TRIG_A_LO, `OFS_TRIG_A_HI))
                trig_a_cfg[entry_idx(reg_addr)] <= reg_wdata;
            if (in_range(reg_addr, `OFS_TRIG_B_LO, `OFS_TRIG_B_HI))
                trig_b_cfg[entry_idx(reg_addr)] <= reg_wdata;
            if (in_range(reg_addr, `OFS_LVDS_LO, `OFS_LVDS_HI))
                lvds_cfg[entry_idx(reg_addr)] <= reg_wdata;
            if (reg_addr == `OFS_TTL_IN)
                ttl_in_cfg <= reg_wdata & `MASK_TTL_IN;
            if (reg_addr == `OFS_TTL_OUT)
                ttl_out_cfg <= reg_wdata & `MASK_TTL_OUT;
            if (reg_addr == `OFS_ECLK_01)
                eclk_01_cfg <= reg_wdata & `MASK_ECLK;
            if (reg_addr == `OFS_ECLK_23)
                eclk_23_cfg <= reg_wdata & `MASK_ECLK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read decode; unmapped offsets return zero
    always_comb
    begin
        rdata_nxt = 16'h0000;
        if (in_range(reg_addr, `OFS_TRIG_A_LO, `OFS_TRIG_A_HI))
            rdata_nxt = trig_a_cfg[entry_idx(reg_addr)];
        else if (in_range(reg_addr, `OFS_TRIG_B_LO, `OFS_TRIG_B_HI))
            rdata_nxt = trig_b_cfg[entry_idx(reg_addr)];
        else if (in_range(reg_addr, `OFS_LVDS_LO, `OFS_LVDS_HI))
            rdata_nxt = lvds_cfg[entry_idx(reg_addr)];
        else
        begin
            case (reg_addr)
                `OFS_ERR_MAKER: rdata_nxt = {cmd_err_r, 3'b000, MAKER_CODE};
                `OFS_PART: rdata_nxt = {4'h0, PART_CODE};
                `OFS_HW_VER: rdata_nxt = {LOGIC_VER_MAJOR, LOGIC_VER_MINOR};
                `OFS_FW_VER: rdata_nxt = {FW_VER_MAJOR, FW_VER_MINOR};
                `OFS_SLOT_RST: rdata_nxt = {8'h00, slot_rst_r};
                `OFS_FAN: rdata_nxt = {fan_sel_r, 5'b00000, fan_area_temp};
                `OFS_LOGIC_TEMP: rdata_nxt = {6'b000000, logic_area_temp};
                `OFS_SLOT_TEMP: rdata_nxt = {6'b000000, slot_area_temp};
                `OFS_TTL_IN: rdata_nxt = ttl_in_cfg;
                `OFS_TTL_OUT: rdata_nxt = ttl_out_cfg;
                `OFS_ECLK_01: rdata_nxt = eclk_01_cfg;
                `OFS_ECLK_23: rdata_nxt = eclk_23_cfg;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync2_r)
    begin
        if (!rst_sync2_r)
        begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end
        else
        begin
            reg_rvalid <= rd_en;
            if (rd_en)
                reg_rdata <= reg_addr[0] ? 16'h0000 : rdata_nxt;
        end
    end

    assign slot_reset_bit = slot_rst_r;
    assign fan_speed_select = fan_sel_r;

endmodule : carrier_config_trigger_regs

/* File: pkg/carrier_regs_defines.svh */
`ifndef CARRIER_REGS_DEFINES_SVH
`define CARRIER_REGS_DEFINES_SVH

// Byte offsets of the carrier register bank
`define OFS_ERR_MAKER 8'h00
`define OFS_PART 8'h02
`define OFS_HW_VER 8'h04
`define OFS_FW_VER 8'h06
`define OFS_SLOT_RST 8'h08
`define OFS_FAN 8'h0a
`define OFS_LOGIC_TEMP 8'h0c
`define OFS_SLOT_TEMP 8'h0e
`define OFS_TRIG_A_LO 8'h10
`define OFS_TRIG_A_HI 8'h1f
`define OFS_TRIG_B_LO 8'h20
`define OFS_TRIG_B_HI 8'h2f
`define OFS_LVDS_LO 8'h30
`define OFS_LVDS_HI 8'h3f
`define OFS_TTL_IN 8'h50
`define OFS_TTL_OUT 8'h52
`define OFS_ECLK_01 8'h58
`define OFS_ECLK_23 8'h5a

// Field positions
`define BIT_CMD_ERR 15
`define BIT_FAN_SEL 15
`define ID_MSB 11
`define TEMP_MSB 9

// Writable masks of the routing and slot reset registers (reserved bits stay zero)
`define MASK_TRIG 16'hffff
`define MASK_TTL_IN 16'hee03
`define MASK_TTL_OUT 16'h8877
`define MASK_ECLK 16'hf7f7
`define MASK_SLOT_RST 16'h00ff

// Reset values
`define FAN_SEL_FACTORY 1'b1
`define SLOT_RST_INIT 8'h00

// Minimum slot reset hold time in ns and at 10 MHz in cycles
`define CLK_PERIOD_NS 100
`define SLOT_RST_MIN_NS 1000
`define SLOT_RST_MIN_CYC ((`SLOT_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: pkg/carrier_regs_pkg.sv */
package carrier_regs_pkg;

    typedef enum logic [2:0]
    {
        SRC_TTL,
        SRC_LVDS,
        SRC_TRIG_A,
        SRC_TRIG_B,
        SRC_RSV4,
        SRC_RSV5,
        SRC_RSV6,
        SRC_RSV7
    } src_type_t;

    typedef logic [15:0] word_t;

endpackage : carrier_regs_pkg

/* File: tb/carrier_regs_chk.sv */
`timescale 1ns/1ps
module carrier_regs_chk (
    // Watched ports
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] module_sel,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic command_error,
    input wire logic [9:0] logic_area_temp,
    input wire logic nv_store,
    input wire logic nv_store_value,
    input wire logic [7:0] slot_reset_bit,
    input wire logic fan_speed_select
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    wire logic rd0 = reg_rd && module_sel == 8'h00;
    wire logic wr0 = reg_wr && module_sel == 8'h00;
    ////////////////////////////////////////////////////////////////////////////////
    a_read_answer: assert property (rd0 |=> reg_rvalid)
        else $error("read not answered");
    a_no_stray: assert property (reg_rvalid |-> $past(rd0))
        else $error("answer without accepted read");
    a_err_sticky: assert property (command_error ##1 !wr0 ##1 rd0 && reg_addr == 8'h00
        |=> reg_rdata[15]) else $error("error flag not set");
    a_err_clear: assert property (wr0 && reg_addr == 8'h00 && reg_wdata[15] && !command_error
        ##1 !command_error ##1 rd0 && reg_addr == 8'h00 |=> !reg_rdata[15])
        else $error("error flag not cleared");
    a_temp_read: assert property (rd0 && reg_addr == 8'h0c
        |=> reg_rdata == {6'h00, $past(logic_area_temp)}) else $error("bad logic temperature");
    a_slot_write: assert property (wr0 && reg_addr == 8'h08
        |=> slot_reset_bit == $past(reg_wdata[7:0])) else $error("slot reset not written");
    a_slot_hold: assert property (!(wr0 && reg_addr == 8'h08) |=> $stable(slot_reset_bit))
        else $error("slot reset changed by itself");
    a_fan_write: assert property (wr0 && reg_addr == 8'h0a |=> fan_speed_select ==
        $past(reg_wdata[15]) && nv_store && nv_store_value == $past(reg_wdata[15]))
        else $error("fan select not written or stored");
    a_store_cause: assert property (nv_store |-> $past(wr0 && reg_addr == 8'h0a))
        else $error("store without fan write");
    c_temp: cover property (rd0 && reg_addr == 8'h0c);
    c_slot: cover property (wr0 && reg_addr == 8'h08 && reg_wdata[7:0] != 8'h00);
    c_err: cover property (command_error);
endmodule : carrier_regs_chk

bind carrier_config_trigger_regs carrier_regs_chk chk_u (.clk, .resetn, .module_sel, .reg_addr,
    .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .command_error, .logic_area_temp,
    .nv_store, .nv_store_value, .slot_reset_bit, .fan_speed_select);

/* File: tb/host_cmd_model.sv */
`timescale 1ns/1ps
`include "carrier_regs_defines.svh"
module host_cmd_model (
    // Clock
    input wire logic clk,
    // Command side
    output logic [7:0] module_sel,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata
);
    initial {module_sel, reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
    // Strobe stands for one edge; released address and data show the inverse, not a stale copy
    task automatic access(input logic [7:0] sel, input logic [7:0] a, input logic w,
        input logic [15:0] d);
        @(posedge clk);
        #1;
        module_sel = sel;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : access
    task automatic hold_reset();
        repeat (`SLOT_RST_MIN_CYC) @(posedge clk);
    endtask : hold_reset
endmodule : host_cmd_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "carrier_regs_defines.svh"
module testbench;
    import carrier_regs_pkg::*;
    // Arbitrary identification values
    localparam logic [11:0] MAKER = 12'h3c7;
    localparam logic [11:0] PART = 12'h2b4;
    localparam logic [7:0] OFS [10] = '{8'h10, 8'h1e, 8'h20, 8'h2e, 8'h30, 8'h3e,
        `OFS_TTL_IN, `OFS_TTL_OUT, `OFS_ECLK_01, `OFS_ECLK_23};
    localparam word_t MSK [10] = '{`MASK_TRIG, `MASK_TRIG, `MASK_TRIG, `MASK_TRIG, `MASK_TRIG,
        `MASK_TRIG, `MASK_TTL_IN, `MASK_TTL_OUT, `MASK_ECLK, `MASK_ECLK};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic command_error = 1'b0;
    logic [9:0] fan_area_temp = 10'h155;
    logic [9:0] logic_area_temp = 10'h000;
    logic [9:0] slot_area_temp = 10'h000;
    logic nv_valid = 1'b0;
    logic nv_fan_speed_select = 1'b0;
    word_t trig_a_cfg [8], trig_b_cfg [8], lvds_cfg [8];
    word_t ttl_in_cfg, ttl_out_cfg, eclk_01_cfg, eclk_23_cfg;
    logic [7:0] module_sel, reg_addr, slot_reset_bit;
    logic reg_wr, reg_rd, reg_rvalid, nv_store, nv_store_value, fan_speed_select;
    word_t reg_wdata, reg_rdata;
    word_t exp_q[$];
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    initial forever #50 clk = ~clk;
    carrier_config_trigger_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART),
        .LOGIC_VER_MAJOR(8'h03), .FW_VER_MINOR(8'h07)) dut_u (.clk, .resetn, .module_sel,
        .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .command_error,
        .fan_area_temp, .logic_area_temp, .slot_area_temp, .nv_valid,
        .nv_fan_speed_select, .nv_store, .nv_store_value, .slot_reset_bit,
        .fan_speed_select, .trig_a_cfg, .trig_b_cfg, .lvds_cfg, .ttl_in_cfg,
        .ttl_out_cfg, .eclk_01_cfg, .eclk_23_cfg);
    host_cmd_model host_u (.clk, .module_sel, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic note_err(input string m);
        err_count++;
        $display("Error at %0t: %s", $time, m);
    endtask : note_err
    task automatic cmp_word(input word_t got, input word_t exp);
        tests_run++;
        if (got !== exp) note_err($sformatf("read %h expected %h", got, exp));
    endtask : cmp_word
    task automatic cmp_bits(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) note_err($sformatf("output %h expected %h", got, exp));
    endtask : cmp_bits
    task automatic rd(input logic [7:0] a, input word_t e);
        exp_q.push_back(e);
        host_u.access(8'h00, a, 1'b0, 16'h0000);
    endtask : rd
    task automatic wr(input logic [7:0] a, input word_t d);
        host_u.access(8'h00, a, 1'b1, d);
    endtask : wr
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // Sampled mid-cycle so registered answers have settled
    always @(negedge clk)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            note_err("timeout");
            give_verdict();
        end
        if (reg_rvalid === 1'b1)
        begin
            if (exp_q.size() == 0) note_err("unexpected read answer");
            else cmp_word(reg_rdata, exp_q.pop_front());
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0] r;
        word_t d;
        void'($urandom(1019));
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (2) @(posedge clk);
        rd(`OFS_ERR_MAKER, {4'h0, MAKER});
        rd(`OFS_PART, {4'h0, PART});
        rd(`OFS_HW_VER, 16'h0300);
        rd(`OFS_FW_VER, 16'h0107);
        rd(`OFS_FAN, {6'h20, fan_area_temp});
        cmp_bits({7'h00, fan_speed_select}, 8'h01);
        $display("Test reset values done");
        @(posedge clk) #1 command_error = 1'b1;
        @(posedge clk) #1 command_error = 1'b0;
        rd(`OFS_ERR_MAKER, {4'h8, MAKER});
        wr(`OFS_ERR_MAKER, 16'h7fff);
        rd(`OFS_ERR_MAKER, {4'h8, MAKER});
        wr(`OFS_ERR_MAKER, 16'h8000);
        rd(`OFS_ERR_MAKER, {4'h0, MAKER});
        wr(`OFS_PART, 16'hffff);
        wr(`OFS_HW_VER, 16'hffff);
        rd(`OFS_PART, {4'h0, PART});
        rd(`OFS_HW_VER, 16'h0300);
        $display("Test error flag done");
        r = 8'($urandom()) | 8'h01;
        wr(`OFS_SLOT_RST, {8'hff, r});
        host_u.hold_reset();
        cmp_bits(slot_reset_bit, r);
        rd(`OFS_SLOT_RST, {8'h00, r});
        wr(`OFS_SLOT_RST, 16'h0000);
        cmp_bits(slot_reset_bit, 8'h00);
        wr(`OFS_FAN, 16'h7fff);
        cmp_bits({7'h00, fan_speed_select}, 8'h00);
        rd(`OFS_FAN, {6'h00, fan_area_temp});
        logic_area_temp = 10'($urandom());
        slot_area_temp = 10'($urandom()) | 10'h200;
        rd(`OFS_LOGIC_TEMP, {6'h00, logic_area_temp});
        rd(`OFS_SLOT_TEMP, {6'h00, slot_area_temp});
        $display("Test control and status done");
        for (int i = 0; i < 10; i++)
        begin
            d = 16'($urandom());
            wr(OFS[i], d);
            if (i == 0) cmp_word(trig_a_cfg[0], d);
            if (i == 3) cmp_word(trig_b_cfg[7], d);
            if (i == 5) cmp_word(lvds_cfg[7], d);
            if (i == 6) cmp_word(ttl_in_cfg, d & MSK[i]);
            if (i == 9) cmp_word(eclk_23_cfg, d & MSK[i]);
            rd(OFS[i], d & MSK[i]);
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(`OFS_TTL_OUT, 16'(i << 4));
            rd(`OFS_TTL_OUT, 16'(i << 4));
        end
        $display("Test routing done");
        host_u.access(8'h01, `OFS_SLOT_RST, 1'b1, 16'h00ff);
        host_u.access(8'h02, `OFS_ERR_MAKER, 1'b0, 16'h0000);
        cmp_bits(slot_reset_bit, 8'h00);
        rd(8'h40, 16'h0000);
        rd(8'h09, 16'h0000);
        repeat (2) @(posedge clk);
        tests_run++;
        if (exp_q.size() != 0) note_err("missing read answer");
        $display("Test selector done");
        @(posedge clk) #1 resetn = 1'b0;
        nv_valid = 1'b1;
        repeat (2) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (4) @(posedge clk);
        #1 cmp_bits({7'h00, fan_speed_select}, 8'h00);
        cmp_word(ttl_out_cfg, 16'h0000);
        rd(`OFS_ECLK_01, 16'h0000);
        rd(`OFS_FAN, {6'h00, fan_area_temp});
        repeat (2) @(posedge clk);
        $display("Test second reset done");
        give_verdict();
    end
endmodule : testbench
